// File: hdl/scmc_pkg.sv
// scmc_pkg: constants and types shared by the clock and power-mode block
// assumes a single 125 MHz system clock; oscillators are modelled as enables
//
// How it works
// - high_low_select low: select 000/001 low clock, 010..111 fast clock /64../2
// - high_low_select high: undivided fast clock, select field ignored
// - moving to the low clock stops the fast oscillator and its dividers
// - halt, idle enable, clock-on-in-idle set: cpu stops, system clock runs
// - halt, idle enable, clock-on-in-idle clear: cpu and system clock stop
// - halt with idle enable clear enters a sleep mode
// - sleep without watchdog stops cpu, watchdog and slow oscillator
// - sleep with watchdog keeps slow oscillator running for the watchdog
// - time-base clock from slow oscillator; on in run and idle, off in sleep
// - low ready flag low in deep sleep, high 2 slow ticks after wake
// - fast ready flag clear at power-on, set once fast oscillator is stable
// - ready flags read-only; bit 4 of the mode register reads zero
// - second register: bits 6~4 and 1 read zero, clock-on-in-idle at bit 7
// - slow run mode keeps the fast clock off, cpu runs from slow clock
// - normal run mode divides the fast clock by 1 to 64
// - fast source is an internal 8MHz oscillator, slow one 32kHz
// - idle with clock on keeps the watchdog clock running
// - idle with clock off stops system oscillator, watchdog and timers run
// - slow oscillator also clocks watchdog and time-base functions
// - halt entry sets power-down flag and clears watchdog time-out flag

package scmc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 125_000_000;
    localparam int HS_OSC_HZ      = 8_000_000;
    localparam int LS_OSC_HZ      = 32_000;
    localparam int HS_TICK_CYCLES = CLK_HZ / HS_OSC_HZ;
    localparam int LS_TICK_CYCLES = CLK_HZ / LS_OSC_HZ;
    localparam int HS_START_NS    = 1000;
    localparam int HS_START_CYCLES =
        (HS_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int LS_READY_TICKS = 2;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int         ADDR_W  = 4;
    localparam logic [3:0] CMC_OFS = 4'h0;
    localparam logic [3:0] ICR_OFS = 4'h1;

    localparam int CMC_SEL_LSB = 5;
    localparam int CMC_LS_RDY  = 3;
    localparam int CMC_HS_RDY  = 2;
    localparam int CMC_IDLE_EN = 1;
    localparam int CMC_HL_SEL  = 0;
    localparam int ICR_SYS_ON  = 7;

    localparam logic [2:0] SEL_RST     = 3'h0;
    localparam logic       IDLE_EN_RST = 1'b1;
    localparam logic       HL_SEL_RST  = 1'b1;
    localparam logic       SYS_ON_RST  = 1'b0;
    localparam logic [2:0] SEL_FIRST_HS = 3'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_IDLE_CLOCK_OFF,
        MODE_IDLE_CLOCK_ON,
        MODE_DEEP_SLEEP_NO_WATCHDOG,
        MODE_SLEEP_WITH_WATCHDOG
    } scmc_mode_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [3:0] addr;
        logic [7:0] wdata;
    } scmc_bus_t;

    typedef struct packed {
        logic system_clock;
        logic cpu_clock;
        logic watchdog_clock;
        logic time_base_clock;
        logic fast_div16;
        logic fast_div64;
    } scmc_clk_en_t;

endpackage

// File: hdl/scmc_osc_tick.sv
// scmc_osc_tick: models an internal rc oscillator as a one-cycle enable
// assumes run_i comes from logic on clk_i

`timescale 1ns/100ps
`default_nettype none

module scmc_osc_tick #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // control
    input  wire logic run_i,
    // tick
    output logic      tick_o
);

    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count;
    wire           wrap = (count == LAST);

    // a stopped oscillator restarts a full period later, as a real one would
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !run_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            count  <= wrap ? '0 : count + 1'b1;
            tick_o <= wrap;
        end
    end

endmodule // scmc_osc_tick

`default_nettype wire

// File: hdl/scmc_clock_mode.sv
// scmc_clock_mode: system clock source selection and power-mode control
// assumes core halt/wake pulses and the watchdog enable are on clk_i

`timescale 1ns/100ps
`default_nettype none

module scmc_clock_mode #(
    parameter int HS_START = scmc_pkg::HS_START_CYCLES
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    // register port
    input  wire logic [3:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 write_i,
    input  wire logic                 read_i,
    output logic      [7:0]           rdata_o,
    // core and watchdog
    input  wire logic                 halt_i,
    input  wire logic                 wake_i,
    input  wire logic                 watchdog_enable_i,
    output logic                      power_down_set_o,
    output logic                      timeout_clear_o,
    // clock enables and status
    output scmc_pkg::scmc_clk_en_t    clk_en_o,
    output logic                      fast_osc_on_o,
    output logic                      slow_osc_on_o,
    output scmc_pkg::scmc_mode_t      mode_o
);

    // ------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------
    scmc_pkg::scmc_bus_t bus;
    logic [2:0]          clock_divider_select;
    logic                high_low_select;
    logic                idle_enable;
    logic                sysclk_on_in_idle;
    logic                high_speed_ready;
    logic                low_speed_ready;

    assign bus = '{write: write_i, read: read_i, addr: addr_i, wdata: wdata_i};

    wire cmc_hit = (bus.addr == scmc_pkg::CMC_OFS);
    wire icr_hit = (bus.addr == scmc_pkg::ICR_OFS);
    wire cmc_wr  = bus.write && cmc_hit;
    wire icr_wr  = bus.write && icr_hit;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            clock_divider_select <= scmc_pkg::SEL_RST;
            idle_enable          <= scmc_pkg::IDLE_EN_RST;
            high_low_select      <= scmc_pkg::HL_SEL_RST;
        end else if (cmc_wr) begin
            clock_divider_select <= bus.wdata[scmc_pkg::CMC_SEL_LSB +: 3];
            idle_enable          <= bus.wdata[scmc_pkg::CMC_IDLE_EN];
            high_low_select      <= bus.wdata[scmc_pkg::CMC_HL_SEL];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sysclk_on_in_idle <= scmc_pkg::SYS_ON_RST;
        end else if (icr_wr) begin
            sysclk_on_in_idle <= bus.wdata[scmc_pkg::ICR_SYS_ON];
        end
    end

    // ready flags read-only, bit 4 zero
    wire [7:0] cmc_view = {clock_divider_select, 1'b0, low_speed_ready,
                           high_speed_ready, idle_enable, high_low_select};
    // only bit 7 implemented here; reset-source flags live elsewhere
    wire [7:0] icr_view = {sysclk_on_in_idle, 7'h00};
    wire [7:0] next_rdata = !bus.read ? 8'h00 :
                            cmc_hit   ? cmc_view :
                            icr_hit   ? icr_view : 8'h00;

    // read data stand for exactly one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // mode state
    // ------------------------------------------------------------
    scmc_pkg::scmc_mode_t state;
    scmc_pkg::scmc_mode_t next_state;

    // select 000/001 with high_low_select low means the slow clock
    wire slow_sel = !high_low_select &&
                    (clock_divider_select < scmc_pkg::SEL_FIRST_HS);
    wire run_mode = (state == scmc_pkg::MODE_NORMAL) ||
                    (state == scmc_pkg::MODE_SLOW);
    wire halt_ok  = halt_i && run_mode;
    wire in_sleep = (state == scmc_pkg::MODE_DEEP_SLEEP_NO_WATCHDOG) ||
                    (state == scmc_pkg::MODE_SLEEP_WITH_WATCHDOG);
    wire run_kind_slow = slow_sel;

    always_comb begin
        next_state = state;
        case (state)
            scmc_pkg::MODE_NORMAL,
            scmc_pkg::MODE_SLOW: begin
                if (halt_i) begin
                    if (!idle_enable) begin
                        next_state = watchdog_enable_i ?
                                     scmc_pkg::MODE_SLEEP_WITH_WATCHDOG :
                                     scmc_pkg::MODE_DEEP_SLEEP_NO_WATCHDOG;
                    end else begin
                        next_state = sysclk_on_in_idle ?
                                     scmc_pkg::MODE_IDLE_CLOCK_ON :
                                     scmc_pkg::MODE_IDLE_CLOCK_OFF;
                    end
                end else begin
                    next_state = run_kind_slow ? scmc_pkg::MODE_SLOW :
                                                 scmc_pkg::MODE_NORMAL;
                end
            end
            scmc_pkg::MODE_IDLE_CLOCK_OFF,
            scmc_pkg::MODE_IDLE_CLOCK_ON,
            scmc_pkg::MODE_DEEP_SLEEP_NO_WATCHDOG,
            scmc_pkg::MODE_SLEEP_WITH_WATCHDOG: begin
                if (wake_i) begin
                    next_state = run_kind_slow ? scmc_pkg::MODE_SLOW :
                                                 scmc_pkg::MODE_NORMAL;
                end
            end
            default: next_state = scmc_pkg::MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= scmc_pkg::MODE_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // halt entry marks power-down and clears time-out
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            power_down_set_o <= 1'b0;
            timeout_clear_o  <= 1'b0;
        end else begin
            power_down_set_o <= halt_ok;
            timeout_clear_o  <= halt_ok;
        end
    end

    // ------------------------------------------------------------
    // oscillators
    // ------------------------------------------------------------
    // fast oscillator off when the system runs from the slow clock
    // idle with clock off stops the system oscillator as well
    wire next_fast_on = !slow_sel &&
                        (run_mode || (state == scmc_pkg::MODE_IDLE_CLOCK_ON));
    // slow oscillator runs everywhere except deep sleep
    wire next_slow_on = (state != scmc_pkg::MODE_DEEP_SLEEP_NO_WATCHDOG);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fast_osc_on_o <= 1'b0;
            slow_osc_on_o <= 1'b0;
        end else begin
            fast_osc_on_o <= next_fast_on;
            slow_osc_on_o <= next_slow_on;
        end
    end

    logic fast_tick;
    logic slow_tick;

    scmc_osc_tick #(.PERIOD(scmc_pkg::HS_TICK_CYCLES)) u_fast_osc (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (fast_osc_on_o),
        .tick_o    (fast_tick)
    );

    scmc_osc_tick #(.PERIOD(scmc_pkg::LS_TICK_CYCLES)) u_slow_osc (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (slow_osc_on_o),
        .tick_o    (slow_tick)
    );

    // ------------------------------------------------------------
    // ready flags
    // ------------------------------------------------------------
    localparam int SW = $clog2(HS_START + 1);
    localparam logic [SW-1:0] HS_LAST = SW'(HS_START);
    localparam logic [1:0]    LS_LAST = 2'(scmc_pkg::LS_READY_TICKS);
    logic [SW-1:0] fast_wait;
    logic [1:0]    slow_wait;

    // fast ready clears at reset and whenever the oscillator stops
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !fast_osc_on_o) begin
            fast_wait        <= '0;
            high_speed_ready <= 1'b0;
        end else begin
            fast_wait        <= (fast_wait == HS_LAST) ? fast_wait :
                                fast_wait + 1'b1;
            high_speed_ready <= (fast_wait == HS_LAST);
        end
    end

    // low ready drops in deep sleep, rises after two slow ticks
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !slow_osc_on_o) begin
            slow_wait       <= 2'h0;
            low_speed_ready <= 1'b0;
        end else begin
            if (slow_tick && (slow_wait != LS_LAST)) begin
                slow_wait <= slow_wait + 2'h1;
            end
            low_speed_ready <= (slow_wait == LS_LAST);
        end
    end

    // ------------------------------------------------------------
    // fast clock prescaler and source selection
    // ------------------------------------------------------------
    // one tap for /2 .. /64: select 010 gives /64, 111 gives /2
    function automatic logic div_tap(input logic [5:0] cnt,
                                     input logic [2:0] sel);
        logic [5:0] mask;
        mask = 6'h3f >> (sel - 3'h2);
        return &(cnt | ~mask);
    endfunction

    logic [5:0] prescale;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !fast_osc_on_o) begin
            prescale <= 6'h00;
        end else if (fast_tick) begin
            prescale <= prescale + 6'h01;
        end
    end

    // high_low_select wins over the select field
    // divided fast clock for selects 010..111
    wire src_tick = high_low_select ? fast_tick :
                    slow_sel        ? slow_tick :
                    (fast_tick && div_tap(prescale, clock_divider_select));

    scmc_pkg::scmc_clk_en_t next_en;

    always_comb begin
        // idle with clock on keeps the system clock for peripherals
        next_en.system_clock    = src_tick &&
                                  (run_mode ||
                                   state == scmc_pkg::MODE_IDLE_CLOCK_ON);
        next_en.cpu_clock       = src_tick && run_mode;
        // watchdog clock follows the slow oscillator
        next_en.watchdog_clock  = slow_tick && next_slow_on;
        // time-base stopped in both sleep modes
        next_en.time_base_clock = slow_tick && !in_sleep;
        // divided taps vanish with the fast oscillator
        next_en.fast_div16      = fast_tick && div_tap(prescale, 3'h4);
        next_en.fast_div64      = fast_tick && div_tap(prescale, 3'h2);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            clk_en_o <= '0;
        end else begin
            clk_en_o <= next_en;
        end
    end

    assign mode_o = state;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence halt_to_sleep_s;
        halt_ok && !idle_enable;
    endsequence

    sequence halt_to_idle_off_s;
        halt_ok && idle_enable && !sysclk_on_in_idle;
    endsequence

    chk_slow_source_gate: assert property (
        run_mode && slow_sel && !slow_tick |=> !clk_en_o.system_clock)
        else $error("system clock ticked without a slow tick");

    chk_fast_source_pass: assert property (
        run_mode && high_low_select && fast_tick
        |=> clk_en_o.system_clock && clk_en_o.cpu_clock)
        else $error("undivided fast tick not passed through");

    chk_fast_osc_stop: assert property (
        state == scmc_pkg::MODE_SLOW && slow_sel
        |=> !fast_osc_on_o ##1 !high_speed_ready)
        else $error("fast oscillator kept running in slow mode");

    chk_idle_clock_on: assert property (
        state == scmc_pkg::MODE_IDLE_CLOCK_ON && src_tick
        |=> clk_en_o.system_clock && !clk_en_o.cpu_clock)
        else $error("idle with clock on lost the system clock");

    chk_idle_clock_off: assert property (
        halt_to_idle_off_s |=> state == scmc_pkg::MODE_IDLE_CLOCK_OFF
        ##1 !clk_en_o.system_clock && !fast_osc_on_o)
        else $error("idle with clock off kept the system clock");

    chk_sleep_entry: assert property (
        halt_to_sleep_s |=> in_sleep ##1 !clk_en_o.cpu_clock)
        else $error("halt without idle enable did not sleep");

    chk_deep_sleep_stop: assert property (
        state == scmc_pkg::MODE_DEEP_SLEEP_NO_WATCHDOG |=> !slow_osc_on_o
        ##1 !clk_en_o.watchdog_clock && !low_speed_ready)
        else $error("deep sleep left the slow oscillator running");

    chk_sleep_watchdog: assert property (
        state == scmc_pkg::MODE_SLEEP_WITH_WATCHDOG && slow_tick
        |=> clk_en_o.watchdog_clock && !clk_en_o.time_base_clock)
        else $error("watchdog clock lost in sleep with watchdog");

    chk_time_base_run: assert property (
        !in_sleep && slow_tick |=> clk_en_o.time_base_clock)
        else $error("time-base tick missing outside sleep");

    chk_fast_ready_time: assert property (
        $rose(fast_osc_on_o) |-> !high_speed_ready [*8])
        else $error("fast ready flag rose too early");

    chk_halt_flags: assert property (
        halt_ok |=> power_down_set_o && timeout_clear_o
        ##1 !power_down_set_o)
        else $error("halt entry did not pulse the status flags");

    chk_read_zero_bits: assert property (
        bus.read && cmc_hit |=> rdata_o[4] == 1'b0)
        else $error("unimplemented mode bit read as one");

endmodule // scmc_clock_mode

`default_nettype wire

// File: sim/scmc_core_model.sv
// scmc_core_model: core side of the clock block in the bench
// assumes bench requests change just after a rising edge of clk_i

`timescale 1ns/100ps
`default_nettype none

module scmc_core_model (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    // bench requests
    input  wire logic                   halt_req_i,
    input  wire logic                   wake_req_i,
    input  wire logic                   watchdog_req_i,
    input  wire scmc_pkg::scmc_clk_en_t clk_en_i,
    // to the clock block
    output logic                        halt_o,
    output logic                        wake_o,
    output logic                        watchdog_enable_o,
    output logic [15:0]                 cpu_ticks_o
);
    // requests leave on a clock edge, like a real core would issue them
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            halt_o            <= 1'b0;
            wake_o            <= 1'b0;
            watchdog_enable_o <= 1'b0;
            cpu_ticks_o       <= 16'h0;
        end else begin
            halt_o            <= halt_req_i;
            wake_o            <= wake_req_i;
            watchdog_enable_o <= watchdog_req_i;
            if (clk_en_i.cpu_clock)
                cpu_ticks_o <= cpu_ticks_o + 16'h1;
        end
    end
endmodule // scmc_core_model

`default_nettype wire

// File: sim/system_clock_mode_control_tb.sv
// system_clock_mode_control_tb: self-checking bench of the clock block
// assumes the block's package is compiled first

`timescale 1ns/100ps
`default_nettype none

module system_clock_mode_control_tb;
    logic                  clk, reset_n, wr, rd_s, halt, wake, wden;
    logic                  halt_req, wake_req, wd_req, pd_set, to_clr;
    logic                  fast_on, slow_on, fast;
    logic [3:0]            addr;
    logic [7:0]            wdata, rdata, r, w;
    logic [15:0]           cpu_ticks, cpu0;
    scmc_pkg::scmc_clk_en_t en;
    scmc_pkg::scmc_mode_t  mode;
    scmc_pkg::scmc_mode_t  em [4] = '{scmc_pkg::MODE_IDLE_CLOCK_OFF,
        scmc_pkg::MODE_IDLE_CLOCK_ON, scmc_pkg::MODE_DEEP_SLEEP_NO_WATCHDOG, scmc_pkg::MODE_SLEEP_WITH_WATCHDOG};
    int                    num_errors = 0;
    int                    total_checks = 0;
    int                    cnt [6];
    int                    g, i;

    scmc_clock_mode #(.HS_START(8)) i_dut (.clk_i(clk), .reset_n_i(reset_n),
        .addr_i(addr), .wdata_i(wdata), .write_i(wr), .read_i(rd_s),
        .rdata_o(rdata), .halt_i(halt), .wake_i(wake),
        .watchdog_enable_i(wden), .power_down_set_o(pd_set),
        .timeout_clear_o(to_clr), .clk_en_o(en), .fast_osc_on_o(fast_on),
        .slow_osc_on_o(slow_on), .mode_o(mode));

    scmc_core_model i_core (.clk_i(clk), .reset_n_i(reset_n),
        .halt_req_i(halt_req), .wake_req_i(wake_req),
        .watchdog_req_i(wd_req), .clk_en_i(en), .halt_o(halt),
        .wake_o(wake), .watchdog_enable_o(wden), .cpu_ticks_o(cpu_ticks));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic timed_out();
        num_errors++;
        tally_and_finish();
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // the trailing idle cycle keeps strobes from being set twice at once
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        tick();
        wr <= 1'b0;
        tick();
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        tick();
        rd_s <= 1'b0;
        d = rdata;
        tick();
    endtask

    task automatic pulse_core(input logic h);
        halt_req <= h;
        wake_req <= ~h;
        tick();
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask

    // gap in cycles between two system clock enables
    task automatic sys_gap(output int gap);
        for (gap = 0; en.system_clock !== 1'b1; gap++) begin
            if (gap > 9000) timed_out();
            tick();
        end
        gap = 0;
        do begin
            tick();
            gap++;
        end while (en.system_clock !== 1'b1 && gap < 9000);
        if (gap >= 9000) timed_out();
    endtask

    // window longer than one slow oscillator period
    task automatic watch();
        cnt = '{0, 0, 0, 0, 0, 0};
        repeat (4000) begin
            tick();
            cnt[0] += en.system_clock;
            cnt[1] += en.watchdog_clock;
            cnt[2] += en.time_base_clock;
            cnt[3] += pd_set;
            cnt[4] += en.fast_div16;
            cnt[5] += en.fast_div64;
        end
    endtask

    function automatic int exp_gap(input logic hl, input logic [2:0] s);
        if (hl) return scmc_pkg::HS_TICK_CYCLES;
        if (s < 3'h2) return scmc_pkg::LS_TICK_CYCLES;
        return scmc_pkg::HS_TICK_CYCLES << (8 - s);
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hc37a7d5c));
        {reset_n, wr, rd_s, halt_req, wake_req, wd_req} = 6'h0;
        addr  = 4'h0;
        wdata = 8'h00;
        tick(3);
        reset_n <= 1'b1;
        bus_rd(4'h0, r);
        check(r, 8'h03);
        bus_rd(4'h1, r);
        check(r, 8'h00);
        tick(2 * scmc_pkg::LS_TICK_CYCLES + 20);
        bus_rd(4'h0, r);
        check(r, 8'h0f);
        repeat (4) begin
            w = 8'($urandom);
            bus_wr(4'h1, w);
            bus_wr(4'h2 + 4'($urandom % 14), ~w);
            bus_rd(4'h1, r);
            check(r, w & 8'h80);
            bus_rd(4'h2 + 4'($urandom % 14), r);
            check(r, 8'h00);
        end
        for (int k = 0; k < 9; k++) begin
            w = {3'(k), 5'($urandom)};
            w[0] = (k == 8);
            bus_wr(4'h0, w);
            fast = w[0] || w[7:6] != 2'b00;
            tick(40);
            // fast ready is read before the clock is relied on
            bus_rd(4'h0, r);
            check(r, {w[7:5], 1'b0, 1'b1, fast, w[1:0]});
            check(fast_on, fast);
            check(mode, fast ? scmc_pkg::MODE_NORMAL
                             : scmc_pkg::MODE_SLOW);
            sys_gap(g);
            sys_gap(g);
            check(g, exp_gap(w[0], w[7:5]));
        end
        for (int k = 0; k < 4; k++) begin
            bus_wr(4'h0, {6'h0, ~k[1], 1'b1});
            bus_wr(4'h1, {k[0], 7'h0});
            wd_req <= k[0];
            tick(2);
            pulse_core(1'b1);
            for (i = 0; pd_set !== 1'b1; i++) begin
                if (i > 4) timed_out();
                tick();
            end
            check(to_clr, 1'b1);
            check(mode, em[k]);
            // an enable launched in the halt cycle still reaches the core
            pulse_core(1'b1);
            cpu0 = cpu_ticks;
            watch();
            check(cnt[3], 0);
            check(cpu_ticks - cpu0, 16'h0);
            check(cnt[0] != 0, k == 1);
            check(cnt[1] != 0, k != 2);
            check(cnt[2] != 0, k < 2);
            check(cnt[4] / (4000 / exp_gap(1'b0, 3'h4)), k == 1);
            check(cnt[5] / (4000 / exp_gap(1'b0, 3'h2)), k == 1);
            check(slow_on, k != 2);
            if (k < 2) check(fast_on, k == 1);
            bus_rd(4'h0, r);
            check(r[3], k != 2);
            pulse_core(1'b0);
            tick(4);
            check(mode, scmc_pkg::MODE_NORMAL);
            if (k == 2) begin
                tick(2 * scmc_pkg::LS_TICK_CYCLES + 20);
                bus_rd(4'h0, r);
                check(r[3], 1'b1);
            end
        end
        tally_and_finish();
    end
endmodule // system_clock_mode_control_tb

`default_nettype wire
